// File: core/i2csf_defines.svh
`ifndef I2CSF_DEFINES_SVH
`define I2CSF_DEFINES_SVH

`define I2CSF_OFF_STAT 8'h00
`define I2CSF_OFF_RCV 8'h04
`define I2CSF_OFF_TRN 8'h08
`define I2CSF_OFF_CTRL 8'h0c
`define I2CSF_OFF_IMASK 8'h10
`define I2CSF_OFF_ISTAT 8'h14

`define I2CSF_B_ACK 15
`define I2CSF_B_TIP 14
`define I2CSF_B_AW 13
`define I2CSF_B_BCL 10
`define I2CSF_B_GC 9
`define I2CSF_B_A10 8
`define I2CSF_B_IWC 7
`define I2CSF_B_OV 6
`define I2CSF_B_DA 5
`define I2CSF_B_P 4
`define I2CSF_B_S 3
`define I2CSF_B_RW 2
`define I2CSF_B_RBF 1
`define I2CSF_B_TBF 0

`define I2CSF_CTRL_TEN 10
`define I2CSF_CTRL_RST 11'h000

`define I2CSF_EV_W 4
`define I2CSF_EV_STOP 0
`define I2CSF_EV_RX 1
`define I2CSF_EV_TXD 2
`define I2CSF_EV_BCL 3
`define I2CSF_EV_RST 4'h0

`define I2CSF_CNT_BYTE 4'h8
`define I2CSF_CNT_ACK 4'h9
`define I2CSF_GC_ADDR 8'h00
`define I2CSF_TEN_PFX 5'h1e
`define I2CSF_BYTE_RST 8'h00
`define I2CSF_WORD_RST 32'h0000_0000

`endif

// File: core/i2csf_pkg.sv
package i2csf_pkg;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ADDR,
      PH_ADDR2,
      PH_DATA
   } i2csf_phase_e;

   typedef enum logic [2:0] {
      RG_STAT,
      RG_RCV,
      RG_TRN,
      RG_CTRL,
      RG_IMASK,
      RG_ISTAT,
      RG_NONE
   } i2csf_reg_e;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } i2csf_apb_req_s;

endpackage : i2csf_pkg

// File: core/i2csf_status_flags.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "i2csf_defines.svh"

//Contract
// - Ack flag: one on NACK, zero on ACK
// - Ack flag changes only at ack end
// - Transmit flag spans byte plus ack
// - Slave ack window: 8th fall to 9th rise
// - Collision during master op sets flag
// - General call flag, cleared at Stop
// - Ten-bit match flag, cleared at Stop
// - Busy transmit write dropped, flag set
// - Unread receive buffer overrun sets flag
module i2csf_status_flags (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic slave_mode_i,
   input wire logic master_active_i,
   input wire logic mst_sda_out_i,
   input wire logic mst_tx_start_i,
   output logic [7:0] tx_data_o,
   output logic irq_o
);

   function automatic i2csf_pkg::i2csf_reg_e reg_dec(input logic [7:0] a);
      if (a == `I2CSF_OFF_STAT) begin
         reg_dec = i2csf_pkg::RG_STAT;
      end else if (a == `I2CSF_OFF_RCV) begin
         reg_dec = i2csf_pkg::RG_RCV;
      end else if (a == `I2CSF_OFF_TRN) begin
         reg_dec = i2csf_pkg::RG_TRN;
      end else if (a == `I2CSF_OFF_CTRL) begin
         reg_dec = i2csf_pkg::RG_CTRL;
      end else if (a == `I2CSF_OFF_IMASK) begin
         reg_dec = i2csf_pkg::RG_IMASK;
      end else if (a == `I2CSF_OFF_ISTAT) begin
         reg_dec = i2csf_pkg::RG_ISTAT;
      end else begin
         reg_dec = i2csf_pkg::RG_NONE;
      end
   endfunction : reg_dec

   i2csf_pkg::i2csf_apb_req_s req;
   i2csf_pkg::i2csf_phase_e phase_ff;
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff, rcv_ff, trn_ff;
   logic [10:0] ctrl_ff;
   logic [`I2CSF_EV_W-1:0] imask_ff, istat_ff, ev;
   logic ack_ff, tip_ff, aw_ff, bcl_ff, gc_ff, a10_ff;
   logic iwc_ff, ov_ff, da_ff, p_ff, s_ff, rw_ff;
   logic rbf_ff, tbf_ff, ack_smp_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, irq_ff;
   logic [15:0] stat;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic byte_done, ack_rise, ack_end;
   logic acc, wr_stat, wr_trn, rd_rcv;
   logic rx_load;

   assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};

   // Pins are asynchronous to the peripheral clock
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_s1_ff <= scl_i;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
      end
   end

   assign scl_rise = scl_s2_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s2_ff & scl_d_ff;
   assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
   assign stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
   assign byte_done = scl_fall & (bit_cnt_ff == `I2CSF_CNT_BYTE);
   assign ack_rise = scl_rise & (bit_cnt_ff == `I2CSF_CNT_BYTE);
   assign ack_end = scl_fall & (bit_cnt_ff == `I2CSF_CNT_ACK);

   // Counts SCL rises within a byte, ack bit is the ninth
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || start_det || stop_det) begin
         bit_cnt_ff <= 4'h0;
      end else if (scl_rise && bit_cnt_ff < `I2CSF_CNT_ACK) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else if (ack_end) begin
         bit_cnt_ff <= 4'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         shift_ff <= `I2CSF_BYTE_RST;
      end else if (scl_rise && bit_cnt_ff < `I2CSF_CNT_BYTE) begin
         shift_ff <= {shift_ff[6:0], sda_s2_ff};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || stop_det) begin
         phase_ff <= i2csf_pkg::PH_IDLE;
      end else if (start_det) begin
         phase_ff <= i2csf_pkg::PH_ADDR;
      end else if (byte_done) begin
         case (phase_ff)
            i2csf_pkg::PH_ADDR: begin
               if (ctrl_ff[`I2CSF_CTRL_TEN] && !shift_ff[0] &&
                   shift_ff[7:1] == {`I2CSF_TEN_PFX, ctrl_ff[9:8]}) begin
                  phase_ff <= i2csf_pkg::PH_ADDR2;
               end else begin
                  phase_ff <= i2csf_pkg::PH_DATA;
               end
            end
            i2csf_pkg::PH_ADDR2: begin
               phase_ff <= i2csf_pkg::PH_DATA;
            end
            default: begin
               phase_ff <= phase_ff;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s_ff <= 1'b0;
         p_ff <= 1'b0;
         rw_ff <= 1'b0;
         da_ff <= 1'b0;
      end else begin
         if (start_det) begin
            s_ff <= 1'b1;
            p_ff <= 1'b0;
         end else if (stop_det) begin
            s_ff <= 1'b0;
            p_ff <= 1'b1;
         end
         if (byte_done && phase_ff == i2csf_pkg::PH_ADDR) begin
            rw_ff <= shift_ff[0];
         end
         if (byte_done) begin
            da_ff <= (phase_ff == i2csf_pkg::PH_DATA);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         gc_ff <= 1'b0;
      end else if (byte_done && slave_mode_i && phase_ff == i2csf_pkg::PH_ADDR &&
                   shift_ff == `I2CSF_GC_ADDR) begin
         gc_ff <= 1'b1;
      end else if (stop_det) begin
         gc_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         a10_ff <= 1'b0;
      end else if (byte_done && slave_mode_i && phase_ff == i2csf_pkg::PH_ADDR2 &&
                   shift_ff == ctrl_ff[7:0]) begin
         a10_ff <= 1'b1;
      end else if (stop_det) begin
         a10_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         aw_ff <= 1'b0;
      end else if (byte_done && slave_mode_i) begin
         aw_ff <= 1'b1;
      end else if (ack_rise || stop_det) begin
         aw_ff <= 1'b0;
      end
   end

   // Busy from start to ack end
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         tip_ff <= 1'b0;
      end else if (mst_tx_start_i) begin
         tip_ff <= 1'b1;
      end else if (ack_end) begin
         tip_ff <= 1'b0;
      end
   end

   // NACK reads high on the line
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ack_smp_ff <= 1'b0;
      end else if (ack_rise && tip_ff) begin
         ack_smp_ff <= sda_s2_ff;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ack_ff <= 1'b0;
      end else if (ack_end && tip_ff) begin
         ack_ff <= ack_smp_ff;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         bcl_ff <= 1'b0;
      end else if (master_active_i && scl_s2_ff && mst_sda_out_i && !sda_s2_ff) begin
         bcl_ff <= 1'b1;
      end else if (wr_stat && req.wdata[`I2CSF_B_BCL]) begin
         bcl_ff <= 1'b0;
      end
   end

   assign acc = psel_i & penable_i & pready_ff;
   assign wr_stat = acc & req.write & (reg_dec(req.addr) == i2csf_pkg::RG_STAT);
   assign wr_trn = acc & req.write & (reg_dec(req.addr) == i2csf_pkg::RG_TRN);
   assign rd_rcv = acc & ~req.write & (reg_dec(req.addr) == i2csf_pkg::RG_RCV);
   assign rx_load = byte_done & ~tip_ff & (phase_ff != i2csf_pkg::PH_IDLE);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         trn_ff <= `I2CSF_BYTE_RST;
         tbf_ff <= 1'b0;
         iwc_ff <= 1'b0;
      end else begin
         if (wr_trn && tip_ff) begin
            iwc_ff <= 1'b1;
         end else if (wr_stat && req.wdata[`I2CSF_B_IWC]) begin
            iwc_ff <= 1'b0;
         end
         if (wr_trn && !tip_ff) begin
            trn_ff <= req.wdata[7:0];
            tbf_ff <= 1'b1;
         end else if (ack_end && tip_ff) begin
            tbf_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rcv_ff <= `I2CSF_BYTE_RST;
         rbf_ff <= 1'b0;
         ov_ff <= 1'b0;
      end else begin
         if (rx_load && rbf_ff) begin
            ov_ff <= 1'b1;
         end else if (wr_stat && req.wdata[`I2CSF_B_OV]) begin
            ov_ff <= 1'b0;
         end
         if (rx_load && !rbf_ff) begin
            rcv_ff <= shift_ff;
            rbf_ff <= 1'b1;
         end else if (rd_rcv) begin
            rbf_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      stat = 16'h0000;
      stat[`I2CSF_B_ACK] = ack_ff;
      stat[`I2CSF_B_TIP] = tip_ff;
      stat[`I2CSF_B_AW] = aw_ff;
      stat[`I2CSF_B_BCL] = bcl_ff;
      stat[`I2CSF_B_GC] = gc_ff;
      stat[`I2CSF_B_A10] = a10_ff;
      stat[`I2CSF_B_IWC] = iwc_ff;
      stat[`I2CSF_B_OV] = ov_ff;
      stat[`I2CSF_B_DA] = da_ff;
      stat[`I2CSF_B_P] = p_ff;
      stat[`I2CSF_B_S] = s_ff;
      stat[`I2CSF_B_RW] = rw_ff;
      stat[`I2CSF_B_RBF] = rbf_ff;
      stat[`I2CSF_B_TBF] = tbf_ff;
   end

   always_comb begin
      ev = `I2CSF_EV_RST;
      ev[`I2CSF_EV_STOP] = stop_det;
      ev[`I2CSF_EV_RX] = rx_load;
      ev[`I2CSF_EV_TXD] = ack_end & tip_ff;
      ev[`I2CSF_EV_BCL] = master_active_i & scl_s2_ff & mst_sda_out_i & ~sda_s2_ff;
   end

   // Set beats a same-cycle write-one clear
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         istat_ff <= `I2CSF_EV_RST;
         imask_ff <= `I2CSF_EV_RST;
         ctrl_ff <= `I2CSF_CTRL_RST;
         irq_ff <= 1'b0;
      end else begin
         if (acc && req.write && reg_dec(req.addr) == i2csf_pkg::RG_ISTAT) begin
            istat_ff <= (istat_ff & ~req.wdata[`I2CSF_EV_W-1:0]) | ev;
         end else begin
            istat_ff <= istat_ff | ev;
         end
         if (acc && req.write && reg_dec(req.addr) == i2csf_pkg::RG_IMASK) begin
            imask_ff <= req.wdata[`I2CSF_EV_W-1:0];
         end
         if (acc && req.write && reg_dec(req.addr) == i2csf_pkg::RG_CTRL) begin
            ctrl_ff <= req.wdata[10:0];
         end
         irq_ff <= |(istat_ff & imask_ff);
      end
   end

   // Ready one cycle after setup: zero wait states, no stall
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= `I2CSF_WORD_RST;
      end else begin
         pready_ff <= psel_i & ~penable_i;
         if (psel_i && !penable_i) begin
            pslverr_ff <= (reg_dec(req.addr) == i2csf_pkg::RG_NONE);
            prdata_ff <= `I2CSF_WORD_RST;
            if (!req.write) begin
               if (reg_dec(req.addr) == i2csf_pkg::RG_STAT) begin
                  prdata_ff <= {16'h0000, stat};
               end else if (reg_dec(req.addr) == i2csf_pkg::RG_RCV) begin
                  prdata_ff <= {24'h000000, rcv_ff};
               end else if (reg_dec(req.addr) == i2csf_pkg::RG_TRN) begin
                  prdata_ff <= {24'h000000, trn_ff};
               end else if (reg_dec(req.addr) == i2csf_pkg::RG_CTRL) begin
                  prdata_ff <= {21'h0, ctrl_ff};
               end else if (reg_dec(req.addr) == i2csf_pkg::RG_IMASK) begin
                  prdata_ff <= {28'h0000000, imask_ff};
               end else if (reg_dec(req.addr) == i2csf_pkg::RG_ISTAT) begin
                  prdata_ff <= {28'h0000000, istat_ff};
               end
            end
         end
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign tx_data_o = trn_ff;
   assign irq_o = irq_ff;

endmodule : i2csf_status_flags

// File: dv/i2csf_bus_partner.sv
`timescale 1ns/1ps
module i2csf_bus_partner (
   input wire logic clk_i,
   output logic scl_o,
   output logic sda_o
);
   // Pulled-up lines: idle high, clock still outside frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge clk_i);
   endtask : gap
   task automatic start_c(input int h);
      sda_o <= 1'b0;
      gap(h);
      scl_o <= 1'b0;
      gap(h);
   endtask : start_c
   task automatic stop_c(input int h);
      sda_o <= 1'b0;
      gap(h);
      scl_o <= 1'b1;
      gap(h);
      sda_o <= 1'b1;
      gap(h);
   endtask : stop_c
   // Sends the top n bits, then lets SDA float back high while SCL is low
   task automatic send(input logic [7:0] v, input int n, input int h);
      for (int i = 7; i > 7 - n; i--) begin
         sda_o <= v[i];
         gap(h);
         scl_o <= 1'b1;
         gap(h);
         scl_o <= 1'b0;
         gap(h);
      end
      sda_o <= 1'b1;
   endtask : send
endmodule : i2csf_bus_partner

// File: dv/i2csf_status_flags_assertions.sv
`timescale 1ns/1ps
`include "i2csf_defines.svh"
module i2csf_status_flags_assertions (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] tx_data_o,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   wire logic wr_done = psel_i && penable_i && pready_o && pwrite_i;
   wire logic trn_wr = wr_done && paddr_i == `I2CSF_OFF_TRN;
   property p_ready; psel_i && !penable_i |=> pready_o; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_pulse; pready_o |=> !pready_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_sel; pready_o |-> psel_i && penable_i; endproperty
   a_sel: assert property (p_sel) else $error("ready outside access");
   property p_err;
      pready_o |-> pslverr_o == !(paddr_i inside {`I2CSF_OFF_STAT, `I2CSF_OFF_RCV, `I2CSF_OFF_TRN,
         `I2CSF_OFF_CTRL, `I2CSF_OFF_IMASK, `I2CSF_OFF_ISTAT});
   endproperty
   a_err: assert property (p_err) else $error("bad error response");
   property p_hole;
      pready_o && !pwrite_i && paddr_i == `I2CSF_OFF_STAT |-> prdata_o[31:16] == 16'h0000 && prdata_o[12:11] == 2'h0;
   endproperty
   a_hole: assert property (p_hole) else $error("unused status bits set");
   property p_hold; !pready_o |-> $stable(prdata_o) && $stable(pslverr_o); endproperty
   a_hold: assert property (p_hold) else $error("response moved");
   property p_tx; !$stable(tx_data_o) |-> $past(trn_wr) && tx_data_o == $past(pwdata_i[7:0]); endproperty
   a_tx: assert property (p_tx) else $error("transmit data moved");
   property p_irq; wr_done && paddr_i == `I2CSF_OFF_IMASK && pwdata_i[3:0] == 4'h0 |-> ##2 !irq_o; endproperty
   a_irq: assert property (p_irq) else $error("masked irq high");
   c_err: cover property (pready_o && pslverr_o);
   c_trn: cover property (trn_wr);
   c_irq: cover property ($rose(irq_o));
endmodule : i2csf_status_flags_assertions
bind i2csf_status_flags i2csf_status_flags_assertions chk_u (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_data_o, .irq_o);

// File: dv/test_i2csf_status_flags.sv
`timescale 1ns/1ps
`include "i2csf_defines.svh"
module test_i2csf_status_flags;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0, prd;
   logic rdy, err, scl, sda, irq;
   logic smode = 1'b0, mact = 1'b0, msda = 1'b1, mtx = 1'b0;
   logic [7:0] txd;
   logic [32:0] q_exp[$], q_msk[$];
   logic [7:0] offs[5] = '{`I2CSF_OFF_STAT, `I2CSF_OFF_RCV, `I2CSF_OFF_CTRL, `I2CSF_OFF_IMASK, `I2CSF_OFF_ISTAT};
   int errors = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   i2csf_bus_partner bus_u (.clk_i(clk), .scl_o(scl), .sda_o(sda));
   i2csf_status_flags dut_u (.sys_clk_i(clk), .srst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .scl_i(scl), .sda_i(sda),
      .slave_mode_i(smode), .master_active_i(mact), .mst_sda_out_i(msda), .mst_tx_start_i(mtx),
      .tx_data_o(txd), .irq_o(irq));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Response watcher pairs each ready with the oldest note
   always @(posedge clk) begin
      if (rdy === 1'b1) begin
         if (q_exp.size() == 0) chk(33'h1_ffff_ffff, 33'h0);
         else chk({err, prd} & q_msk.pop_front(), q_exp.pop_front());
      end
   end
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e,
         input logic [32:0] m);
      int n;
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      psel <= 1'b1;
      pen <= 1'b0;
      padr <= a;
      pwr <= w;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         errors++;
         report_and_stop();
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic st(input int b, input logic v);
      apb(`I2CSF_OFF_STAT, 1'b0, 32'h0, {1'b0, 32'(v) << b}, {1'b1, 32'h1 << b});
   endtask : st
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, 33'h0, 33'h1_0000_0000);
   endtask : wr
   initial begin
      logic [7:0] d;
      logic [9:0] own;
      int h;
      void'($urandom(70946));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) apb(offs[i], 1'b0, 32'h0, 33'h0, 33'h1_ffff_ffff);
      wr(`I2CSF_OFF_STAT, 32'hffff_ffff);
      apb(`I2CSF_OFF_STAT, 1'b0, 32'h0, 33'h0, 33'h1_ffff_ffff);
      apb(8'h18, 1'b0, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
      apb(8'h18, 1'b1, 32'h5, 33'h1_0000_0000, 33'h1_0000_0000);
      $display("register test done");
      smode <= 1'b1;
      h = $urandom_range(4, 9);
      bus_u.start_c(h);
      bus_u.send(`I2CSF_GC_ADDR, 8, h);
      st(`I2CSF_B_AW, 1'b1);
      bus_u.send(8'h00, 1, h);
      st(`I2CSF_B_AW, 1'b0);
      st(`I2CSF_B_GC, 1'b1);
      st(`I2CSF_B_BCL, 1'b0);
      repeat (2) begin
         bus_u.send(8'($urandom()), 8, h);
         bus_u.send(8'h00, 1, h);
      end
      st(`I2CSF_B_OV, 1'b1);
      bus_u.stop_c(h);
      st(`I2CSF_B_GC, 1'b0);
      wr(`I2CSF_OFF_STAT, 32'h1 << `I2CSF_B_OV);
      st(`I2CSF_B_OV, 1'b0);
      $display("slave receive test done");
      own = 10'($urandom());
      wr(`I2CSF_OFF_CTRL, {21'h0, 1'b1, own});
      for (int k = 0; k < 2; k++) begin
         bus_u.start_c(h);
         bus_u.send({`I2CSF_TEN_PFX, own[9:8], 1'b0}, 8, h);
         bus_u.send(8'h00, 1, h);
         bus_u.send(own[7:0] ^ 8'(k), 8, h);
         bus_u.send(8'h00, 1, h);
         st(`I2CSF_B_A10, k == 0);
         bus_u.stop_c(h);
         st(`I2CSF_B_A10, 1'b0);
      end
      $display("ten-bit test done");
      smode <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         d = 8'($urandom());
         wr(`I2CSF_OFF_TRN, {24'h0, d});
         chk({25'h0, txd}, {25'h0, d});
         bus_u.start_c(h);
         mtx <= 1'b1;
         @(posedge clk);
         mtx <= 1'b0;
         st(`I2CSF_B_TIP, 1'b1);
         wr(`I2CSF_OFF_TRN, ~{24'h0, d});
         chk({25'h0, txd}, {25'h0, d});
         st(`I2CSF_B_IWC, 1'b1);
         bus_u.send(d, 8, h);
         st(`I2CSF_B_ACK, k == 1);
         st(`I2CSF_B_AW, 1'b0);
         bus_u.send({k == 0, 7'h0}, 1, h);
         st(`I2CSF_B_ACK, k == 0);
         st(`I2CSF_B_TIP, 1'b0);
         bus_u.stop_c(h);
         wr(`I2CSF_OFF_STAT, 32'h1 << `I2CSF_B_IWC);
         st(`I2CSF_B_IWC, 1'b0);
      end
      $display("master transmit test done");
      wr(`I2CSF_OFF_IMASK, 32'h8);
      mact <= 1'b1;
      bus_u.start_c(h);
      st(`I2CSF_B_BCL, 1'b1);
      chk({32'h0, irq}, 33'h1);
      mact <= 1'b0;
      bus_u.stop_c(h);
      wr(`I2CSF_OFF_IMASK, 32'h0);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
      wr(`I2CSF_OFF_STAT, 32'h1 << `I2CSF_B_BCL);
      st(`I2CSF_B_BCL, 1'b0);
      wr(`I2CSF_OFF_ISTAT, 32'hf);
      apb(`I2CSF_OFF_ISTAT, 1'b0, 32'h0, 33'h0, 33'h1_0000_000f);
      $display("collision test done");
      report_and_stop();
   end
endmodule : test_i2csf_status_flags
